// File: src/scb_pkg.sv
// scb_pkg: offsets, field positions, reset values and timing counts of the
// switch configuration register bank.
// assumes a 25 MHz core clock and 16-bit registers addressed by register id.
package scb_pkg;

	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int AGE_STEP_S = 1; // seconds per age code step
	localparam int AGE_STEP_CYCLES = AGE_STEP_S * CLK_HZ;

	// register ids
	localparam logic [6:0] OFS_SYS1 = 7'h00;
	localparam logic [6:0] OFS_SYS2 = 7'h01;
	localparam logic [6:0] OFS_SYS3 = 7'h02;
	localparam logic [6:0] OFS_RSVD = 7'h03;
	localparam logic [6:0] OFS_TEST = 7'h04;
	localparam logic [6:0] OFS_PHYV = 7'h05;
	localparam logic [6:0] OFS_MIRROR = 7'h06;
	localparam logic [6:0] OFS_PORT0 = 7'h0D;
	localparam logic [6:0] OFS_IND2 = 7'h44;
	localparam logic [6:0] OFS_IND3 = 7'h45;
	localparam logic [6:0] OFS_IND4 = 7'h46;
	localparam logic [6:0] OFS_CHECKSUM = 7'h47;

	// writable bits (reserved bits read as zero)
	localparam logic [15:0] MASK_SYS1 = 16'hF3EC;
	localparam logic [15:0] MASK_SYS3 = 16'h673D;
	localparam logic [15:0] MASK_MIRROR = 16'h7FFF;
	localparam logic [15:0] MASK_PORT0 = 16'hFEDC;

	// reset values
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_TEST = 16'h0008;
	localparam logic [15:0] RST_PORT0 = 16'h000C;
	localparam logic [15:0] RSVD_VALUE = 16'h0114;

	// field positions
	localparam int SYS1_QLIM = 15;
	localparam int SYS1_FLOOD = 14;
	localparam int SYS1_AUTOSEC = 13;
	localparam int SYS1_AGE = 12;
	localparam int SYS1_INMIR = 9;
	localparam int SYS1_OUTMIR = 8;
	localparam int SYS1_WM_LO = 6;
	localparam int SYS1_P0IF = 5;
	localparam int SYS1_TRUNK = 3;
	localparam int SYS1_TMO = 2;
	localparam int SYS2_AGE_LO = 8;
	localparam int SYS2_DLY_LO = 6;
	localparam int SYS2_STORM_LO = 4;
	localparam int SYS2_SBO = 3;
	localparam int SYS2_REC = 2;
	localparam int SYS2_HASH_LO = 0;
	localparam int SYS3_PHYRST = 14;
	localparam int SYS3_AGING_RESOLUTION = 10;
	localparam int SYS3_BPGAPEN = 9;
	localparam int SYS3_SHORT_GAP_SELECT = 8;
	localparam int SYS3_SG16 = 5;
	localparam int SYS3_BP_COLLISION_MODE = 4;
	localparam int SYS3_BPGAP_LO = 2;
	localparam int TEST_WM_LO = 10;
	localparam int PHYV_ADDR = 15;
	localparam int PHYV_SLOW = 14;
	localparam int PHYV_ORDER = 13;
	localparam int MIR_MON_LO = 10;
	localparam int MIR_IN_LO = 5;
	localparam int MIR_OUT_LO = 0;
	localparam int P0_UPLINK_LO = 10;
	localparam int P0_STORM = 7;
	localparam int P0_SEC = 6;

	// decoded values
	localparam logic [6:0] GAP_NORMAL_BT = 7'h60; // 96 bit times
	localparam logic [6:0] GAP_SHORT_BT = 7'h40; // 64 bit times
	localparam logic [4:0] PHY_ADDR_HIGH = 5'h10; // 16

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [15:0] data;
	} scb_reg_req_s;

endpackage : scb_pkg

// File: src/scb_age_ticker.sv
// scb_age_ticker: aging scan pacing, one scan pulse per age limit period.
// assumes enable and limit come from registers on the same clock.
`timescale 1ns/10ps
module scb_age_ticker #(
	parameter int SEC_CYCLES = scb_pkg::AGE_STEP_CYCLES // cycles per second
) (
	input wire logic core_clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic enable, // aging running
	input wire logic slow, // halve the aging rate
	input wire logic [8:0] limitSec, // seconds per scan, 1..256
	output logic scanPulse // one-cycle aging scan start
);
	localparam int CW = $clog2(SEC_CYCLES + 1);
	typedef struct packed {
		logic [CW-1:0] cyc;
		logic half;
		logic [8:0] sec;
		logic scan;
	} scb_age_state_s;
	scb_age_state_s st, next_st;

	// stopped aging parks all counters at zero
	always_comb begin
		next_st = st;
		next_st.scan = 1'b0;
		if (!enable) begin
			next_st = '0;
		end else if (st.cyc == CW'(SEC_CYCLES - 1)) begin
			next_st.cyc = '0;
			next_st.half = slow & ~st.half;
			if (!slow || st.half) begin
				if (st.sec + 9'h001 >= limitSec) begin
					next_st.sec = '0;
					next_st.scan = 1'b1;
				end else begin
					next_st.sec = st.sec + 9'h001;
				end
			end
		end else begin
			next_st.cyc = st.cyc + CW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign scanPulse = st.scan;

	scan_gate_a: assert property (@(posedge core_clk) disable iff (rst) !enable |=> !scanPulse)
		else $error("aging scan while aging disabled");
endmodule : scb_age_ticker

// File: src/scb_storm_guard.sv
// scb_storm_guard: broadcast storm state with hysteresis around the threshold.
// assumes count is the port's buffered broadcast frame count, same clock.
`timescale 1ns/10ps
module scb_storm_guard (
	input wire logic core_clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic enable, // storm control on for the port
	input wire logic [6:0] count, // broadcast frames accumulated
	input wire logic [6:0] threshold, // storm threshold in frames
	output logic stormed // new broadcasts must be dropped
);
	typedef struct packed {
		logic stormed;
	} scb_storm_state_s;
	scb_storm_state_s st, next_st;

	// equal count holds the state so the flag does not chatter
	always_comb begin
		next_st = st;
		if (!enable || count < threshold) begin
			next_st.stormed = 1'b0;
		end else if (count > threshold) begin
			next_st.stormed = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign stormed = st.stormed;

	storm_set_a: assert property (@(posedge core_clk) disable iff (rst)
		(enable && count > threshold) |=> stormed)
		else $error("storm not flagged above threshold");
endmodule : scb_storm_guard

// File: src/scb_config_bank.sv
// scb_config_bank: global and port 0 configuration registers of the switch,
// with the decisions that those fields steer.
// assumes one request per cycle on the register port, all inputs on core_clk.
// Functional notes
// - queue limited to watermark only when bit set
// - unknown unicast floods VLAN or goes to uplink
// - auto security disables port on violation
// - aging runs only while enabled
// - mirror enables and three 5-bit port ids
// - watermark code picks depth by memory size
// - port 0 interface select, reduced or full
// - trunk member from assignment or source MAC
// - frame timeout on when bit is zero
// - age limit one to 256 seconds
// - frame delay limit one to four seconds
// - storm threshold 16 to 64 frames
// - short back-off limits to three slots
// - keep retrying after sixteen collisions
// - hash bit pair chosen from source MAC
// - PHY reset on link down unless inhibited
// - normal and backpressure inter-packet gaps
// - backpressure by carrier or by collision
// - backpressure when free blocks below watermark
// - PHY address range, slow clock, port order
// - storm drops new broadcasts until below threshold
// - secured port drops unknown or moved source
`timescale 1ns/10ps
module scb_config_bank #(
	parameter int SEC_CYCLES = scb_pkg::AGE_STEP_CYCLES // cycles per aging second
) (
	input wire logic core_clk, // system clock
	input wire logic rst, // sync reset, high
	input scb_pkg::scb_reg_req_s regReq, // register read/write request
	output logic [15:0] regRdData, // read data
	output logic regRdValid, // read data valid pulse
	output logic queueLimited, // output queues capped
	output logic [9:0] queueLimit, // cap in frames
	output logic queueTestMode, // watermark test code
	output logic ingressMirrorEnable, // incoming monitoring
	output logic egressMirrorEnable, // outgoing monitoring
	output logic [4:0] monitoredPortId, // monitored port
	output logic [4:0] ingressSnoopPortId, // snoop port, incoming
	output logic [4:0] egressSnoopPortId, // snoop port, outgoing
	output logic portZeroMiiMode, // 1: full interface on port 0
	output logic agingEnable, // aging running
	output logic ageScan, // aging scan pulse
	output logic [8:0] ageLimitSec, // age limit in seconds
	output logic frameTimeoutOn, // discard late frames
	output logic [2:0] frameDelaySec, // frame delay limit in seconds
	output logic [6:0] bcastThreshold, // storm threshold in frames
	output logic shortBackoffEnable, // back-off at most 3 slots
	output logic excessCollisionRetry, // retry past 16 collisions
	output logic [6:0] normalGapBt, // inter-packet gap, bit times
	output logic [6:0] bpGapBt, // backpressure gap, bit times
	output logic bpCollisionMode, // 1: collision based backpressure
	output logic bpAssert, // backpressure wanted
	output logic [4:0] phyAddrBase, // first PHY management address
	output logic mgmtClockSlow, // slow management clock
	output logic phyPortOrderReverse, // reversed PHY numbering
	output logic [7:0] phyResetReq, // per-port PHY reset pulse
	input wire logic fwdReq, // unknown unicast from port 0
	input wire logic [7:0] fwdVlanMask, // port 0 VLAN members
	output logic [7:0] fwdDestMask, // destination ports
	output logic fwdDestValid, // destination valid pulse
	input wire logic trunkReq, // trunk selection request
	input wire logic [7:0] srcMacLow, // source MAC bits 7:0
	input wire logic [1:0] trunkAssign, // port based member
	output logic [1:0] trunkMember, // chosen member
	output logic trunkValid, // member valid pulse
	input wire logic rxReq, // source check of a port 0 frame
	input wire logic saKnown, // source address in table
	input wire logic [2:0] saPort, // port the source was learned on
	output logic rxDrop, // drop the frame
	output logic rxValid, // drop decision valid pulse
	output logic portZeroDisabled, // port 0 disabled by security
	input wire logic bcastArrive, // broadcast arrives on port 0
	input wire logic [6:0] bcastCount, // port 0 buffered broadcasts
	output logic bcastDrop, // drop that broadcast
	input wire logic [7:0] linkDown, // per-port link down pulse
	input wire logic [9:0] freeBlocks // free 2K buffer blocks
);
	typedef struct packed {
		logic [15:0] sys1;
		logic [15:0] sys2;
		logic [15:0] sys3;
		logic [15:0] test;
		logic [15:0] phyv;
		logic [15:0] mirror;
		logic [15:0] port0;
		logic [15:0] ind2;
		logic [15:0] ind3;
		logic [15:0] ind4;
		logic [15:0] rdData;
		logic rdValid;
		logic [9:0] queueLimit;
		logic queueTestMode;
		logic [8:0] ageLimitSec;
		logic [2:0] frameDelaySec;
		logic [6:0] bcastThreshold;
		logic [6:0] normalGap;
		logic [6:0] bpGap;
		logic bpAssert;
		logic [4:0] phyAddrBase;
		logic [7:0] phyReset;
		logic [7:0] fwdDest;
		logic fwdValid;
		logic [1:0] trunkMember;
		logic trunkValid;
		logic rxDrop;
		logic rxValid;
		logic portDisabled;
		logic bcastDrop;
		logic timeoutOn;
	} scb_bank_state_s;

	scb_bank_state_s st, next_st;
	logic stormed;
	// two bits of a register at a field position
	function automatic logic [1:0] field2(input logic [15:0] r, input int lo);
		field2 = r[lo +: 2];
	endfunction : field2
	// 8-bit wrapping sum of both bytes of a register
	function automatic logic [7:0] byteSum(input logic [7:0] acc, input logic [15:0] r);
		byteSum = acc + r[15:8] + r[7:0];
	endfunction : byteSum

	// queue depth, halved for the small memory
	function automatic logic [9:0] wmDepth(input logic [1:0] code, input logic big);
		logic [9:0] d;
		case (code)
		2'h0: d = 10'h080;
		2'h1: d = 10'h200;
		2'h2: d = 10'h300;
		default: d = 10'h000;
		endcase
		wmDepth = big ? d : (d >> 1);
	endfunction : wmDepth

	// checksum covers every held word including the fixed one
	logic [7:0] sumByte;
	always_comb begin
		sumByte = 8'h00;
		sumByte = byteSum(sumByte, st.sys1);
		sumByte = byteSum(sumByte, st.sys2);
		sumByte = byteSum(sumByte, st.sys3);
		sumByte = byteSum(sumByte, scb_pkg::RSVD_VALUE);
		sumByte = byteSum(sumByte, st.test);
		sumByte = byteSum(sumByte, st.phyv);
		sumByte = byteSum(sumByte, st.mirror);
		sumByte = byteSum(sumByte, st.port0);
		sumByte = byteSum(sumByte, st.ind2);
		sumByte = byteSum(sumByte, st.ind3);
		sumByte = byteSum(sumByte, st.ind4);
	end

	// register access, derived settings and per-request decisions
	always_comb begin
		logic secViolation;
		logic [2:0] uplink;
		logic [1:0] wsel;
		secViolation = 1'b0;
		uplink = st.port0[scb_pkg::P0_UPLINK_LO +: 3];
		wsel = field2(st.test, scb_pkg::TEST_WM_LO);
		next_st = st;
		next_st.rdValid = 1'b0;
		next_st.fwdValid = 1'b0;
		next_st.trunkValid = 1'b0;
		next_st.rxValid = 1'b0;
		next_st.rxDrop = 1'b0;
		if (regReq.wr) begin
			case (regReq.addr)
			scb_pkg::OFS_SYS1: next_st.sys1 = regReq.data & scb_pkg::MASK_SYS1;
			scb_pkg::OFS_SYS2: next_st.sys2 = regReq.data;
			scb_pkg::OFS_SYS3: next_st.sys3 = regReq.data & scb_pkg::MASK_SYS3;
			scb_pkg::OFS_TEST: next_st.test = regReq.data;
			scb_pkg::OFS_PHYV: next_st.phyv = regReq.data;
			scb_pkg::OFS_MIRROR: next_st.mirror = regReq.data & scb_pkg::MASK_MIRROR;
			scb_pkg::OFS_PORT0: begin
				next_st.port0 = regReq.data & scb_pkg::MASK_PORT0;
				next_st.portDisabled = 1'b0; // rewriting the port re-enables it
			end
			scb_pkg::OFS_IND2: next_st.ind2 = regReq.data;
			scb_pkg::OFS_IND3: next_st.ind3 = regReq.data;
			scb_pkg::OFS_IND4: next_st.ind4 = regReq.data;
			default: ; // fixed, read-only and unmapped ids ignore writes
			endcase
		end
		// reads see the value before a same-cycle write
		if (regReq.rd) begin
			next_st.rdValid = 1'b1;
			case (regReq.addr)
			scb_pkg::OFS_SYS1: next_st.rdData = st.sys1;
			scb_pkg::OFS_SYS2: next_st.rdData = st.sys2;
			scb_pkg::OFS_SYS3: next_st.rdData = st.sys3;
			scb_pkg::OFS_RSVD: next_st.rdData = scb_pkg::RSVD_VALUE;
			scb_pkg::OFS_TEST: next_st.rdData = st.test;
			scb_pkg::OFS_PHYV: next_st.rdData = st.phyv;
			scb_pkg::OFS_MIRROR: next_st.rdData = st.mirror;
			scb_pkg::OFS_PORT0: next_st.rdData = st.port0;
			scb_pkg::OFS_IND2: next_st.rdData = st.ind2;
			scb_pkg::OFS_IND3: next_st.rdData = st.ind3;
			scb_pkg::OFS_IND4: next_st.rdData = st.ind4;
			scb_pkg::OFS_CHECKSUM: next_st.rdData = {sumByte, 8'h00};
			default: next_st.rdData = 16'h0000;
			endcase
		end
		// settings follow the registers one cycle later
		next_st.queueLimit = wmDepth(field2(st.sys1, scb_pkg::SYS1_WM_LO),
			st.sys3[scb_pkg::SYS3_SG16]);
		next_st.queueTestMode = field2(st.sys1, scb_pkg::SYS1_WM_LO) == 2'h3;
		next_st.timeoutOn = ~st.sys1[scb_pkg::SYS1_TMO];
		next_st.ageLimitSec = {1'b0, st.sys2[scb_pkg::SYS2_AGE_LO +: 8]} + 9'h001;
		next_st.frameDelaySec = {1'b0, field2(st.sys2, scb_pkg::SYS2_DLY_LO)} + 3'h1;
		next_st.bcastThreshold = 7'(({5'h00, field2(st.sys2, scb_pkg::SYS2_STORM_LO)}
			+ 7'h01) << 4);
		next_st.normalGap = st.sys3[scb_pkg::SYS3_SHORT_GAP_SELECT] ? scb_pkg::GAP_SHORT_BT
			: scb_pkg::GAP_NORMAL_BT;
		if (!st.sys3[scb_pkg::SYS3_BPGAPEN]) begin
			next_st.bpGap = scb_pkg::GAP_NORMAL_BT;
		end else begin
			case (field2(st.sys3, scb_pkg::SYS3_BPGAP_LO))
			2'h0: next_st.bpGap = 7'h30;
			2'h1: next_st.bpGap = 7'h38;
			2'h2: next_st.bpGap = 7'h41;
			default: next_st.bpGap = 7'h48;
			endcase
		end
		// test code never raises backpressure
		case (wsel)
		2'h0: next_st.bpAssert = freeBlocks < 10'h004;
		2'h1: next_st.bpAssert = freeBlocks < 10'h008;
		2'h2: next_st.bpAssert = freeBlocks < 10'h010;
		default: next_st.bpAssert = 1'b0;
		endcase
		next_st.phyAddrBase = st.phyv[scb_pkg::PHYV_ADDR] ? scb_pkg::PHY_ADDR_HIGH
			: 5'h00;
		next_st.phyReset = linkDown & {8{~st.sys3[scb_pkg::SYS3_PHYRST]}};
		// port 0 being its own uplink counts as no uplink, so the frame floods the VLAN
		if (fwdReq) begin
			next_st.fwdValid = 1'b1;
			if (st.sys1[scb_pkg::SYS1_FLOOD] && uplink != 3'h0) begin
				next_st.fwdDest = 8'h01 << uplink;
			end else begin
				next_st.fwdDest = fwdVlanMask & 8'hFE;
			end
		end
		if (trunkReq) begin
			next_st.trunkValid = 1'b1;
			next_st.trunkMember = st.sys1[scb_pkg::SYS1_TRUNK]
				? field2({8'h00, srcMacLow}, 2 * int'(field2(st.sys2, scb_pkg::SYS2_HASH_LO)))
				: trunkAssign;
		end
		if (rxReq) begin
			next_st.rxValid = 1'b1;
			secViolation = st.port0[scb_pkg::P0_SEC] && (!saKnown || saPort != 3'h0);
			next_st.rxDrop = secViolation;
			if (secViolation && st.sys1[scb_pkg::SYS1_AUTOSEC]) begin
				next_st.portDisabled = 1'b1;
			end
		end
		next_st.bcastDrop = stormed && bcastArrive;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st <= '0;
			st.test <= scb_pkg::RST_TEST;
			st.port0 <= scb_pkg::RST_PORT0;
			st.normalGap <= scb_pkg::GAP_NORMAL_BT;
			st.bpGap <= scb_pkg::GAP_NORMAL_BT;
		end else begin
			st <= next_st;
		end
	end

	// aging pacing; slow resolution halves the rate
	scb_age_ticker #(.SEC_CYCLES(SEC_CYCLES)) ageTicker (
		.core_clk(core_clk),
		.rst(rst),
		.enable(st.sys1[scb_pkg::SYS1_AGE]),
		.slow(st.sys3[scb_pkg::SYS3_AGING_RESOLUTION]),
		.limitSec(st.ageLimitSec),
		.scanPulse(ageScan)
	);

	// storm state for port 0
	scb_storm_guard stormGuard (
		.core_clk(core_clk),
		.rst(rst),
		.enable(st.port0[scb_pkg::P0_STORM]),
		.count(bcastCount),
		.threshold(st.bcastThreshold),
		.stormed(stormed)
	);

	// outputs straight from the state flops
	assign regRdData = st.rdData;
	assign regRdValid = st.rdValid;
	assign queueLimited = st.sys1[scb_pkg::SYS1_QLIM];
	assign queueLimit = st.queueLimit;
	assign queueTestMode = st.queueTestMode;
	assign ingressMirrorEnable = st.sys1[scb_pkg::SYS1_INMIR];
	assign egressMirrorEnable = st.sys1[scb_pkg::SYS1_OUTMIR];
	assign monitoredPortId = st.mirror[scb_pkg::MIR_MON_LO +: 5];
	assign ingressSnoopPortId = st.mirror[scb_pkg::MIR_IN_LO +: 5];
	assign egressSnoopPortId = st.mirror[scb_pkg::MIR_OUT_LO +: 5];
	assign portZeroMiiMode = st.sys1[scb_pkg::SYS1_P0IF];
	assign agingEnable = st.sys1[scb_pkg::SYS1_AGE];
	assign ageLimitSec = st.ageLimitSec;
	assign frameTimeoutOn = st.timeoutOn;
	assign frameDelaySec = st.frameDelaySec;
	assign bcastThreshold = st.bcastThreshold;
	assign shortBackoffEnable = st.sys2[scb_pkg::SYS2_SBO];
	assign excessCollisionRetry = st.sys2[scb_pkg::SYS2_REC];
	assign normalGapBt = st.normalGap;
	assign bpGapBt = st.bpGap;
	assign bpCollisionMode = st.sys3[scb_pkg::SYS3_BP_COLLISION_MODE];
	assign bpAssert = st.bpAssert;
	assign phyAddrBase = st.phyAddrBase;
	assign mgmtClockSlow = st.phyv[scb_pkg::PHYV_SLOW];
	assign phyPortOrderReverse = st.phyv[scb_pkg::PHYV_ORDER];
	assign phyResetReq = st.phyReset;
	assign fwdDestMask = st.fwdDest;
	assign fwdDestValid = st.fwdValid;
	assign trunkMember = st.trunkMember;
	assign trunkValid = st.trunkValid;
	assign rxDrop = st.rxDrop;
	assign rxValid = st.rxValid;
	assign portZeroDisabled = st.portDisabled;
	assign bcastDrop = st.bcastDrop;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence wrSys2;
		regReq.wr && regReq.addr == scb_pkg::OFS_SYS2;
	endsequence
	sequence rdSys2;
		regReq.rd && !regReq.wr && regReq.addr == scb_pkg::OFS_SYS2;
	endsequence

	read_back_a: assert property (wrSys2 ##1 rdSys2 |=> regRdValid && regRdData == $past(regReq.data, 2))
		else $error("register read back mismatch");
	queue_depth_a: assert property ((queueLimited && st.sys1[7:6] == 2'h1 && !st.sys3[5])
		|=> queueLimit == 10'h100)
		else $error("wrong queue cap for small memory");
	flood_uplink_a: assert property ((fwdReq && st.sys1[14] && st.port0[15:10] == 6'h03)
		|=> fwdDestValid && fwdDestMask == 8'h08)
		else $error("unknown unicast not sent to uplink");
	flood_vlan_a: assert property ((fwdReq && !st.sys1[14])
		|=> fwdDestMask == ($past(fwdVlanMask) & 8'hFE))
		else $error("flood mask wrong");
	auto_disable_a: assert property ((rxReq && st.port0[6] && !saKnown && st.sys1[13])
		|=> rxDrop ##0 portZeroDisabled)
		else $error("violation did not disable port");
	age_limit_a: assert property (st.sys2[15:8] == 8'hFF |=> ageLimitSec == 9'h100)
		else $error("age limit not 256 seconds");
	trunk_hash_a: assert property ((trunkReq && st.sys1[3] && st.sys2[1:0] == 2'h3)
		|=> trunkMember == $past(srcMacLow[7:6]))
		else $error("trunk hash bits wrong");
	phy_reset_a: assert property ((linkDown[2] && !st.sys3[14]) |=> phyResetReq[2])
		else $error("no PHY reset on link down");
	bp_gap_a: assert property ((st.sys3[9] && st.sys3[3:2] == 2'h2) |=> bpGapBt == 7'h41)
		else $error("backpressure gap not 65");
	bp_trigger_a: assert property ((st.test[11:10] == 2'h0 && freeBlocks == 10'h003)
		|=> bpAssert)
		else $error("backpressure missing below 4 blocks");
endmodule : scb_config_bank

// File: bench/tb.sv
// tb: self-checking bench for the switch configuration register bank.
// assumes reads answer one cycle late and derived fields lag writes by one cycle.
`timescale 1ns/10ps
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	scb_pkg::scb_reg_req_s regReq = '0;
	logic [15:0] regRdData;
	logic regRdValid, queueLimited, queueTestMode, ingressMirrorEnable, egressMirrorEnable;
	logic portZeroMiiMode, agingEnable, ageScan, frameTimeoutOn, shortBackoffEnable;
	logic excessCollisionRetry, bpCollisionMode, bpAssert, mgmtClockSlow, phyPortOrderReverse;
	logic fwdDestValid, trunkValid, rxDrop, rxValid, portZeroDisabled, bcastDrop;
	logic [9:0] queueLimit;
	logic [9:0] freeBlocks = 10'h3FF;
	logic [4:0] monitoredPortId, ingressSnoopPortId, egressSnoopPortId, phyAddrBase;
	logic [8:0] ageLimitSec;
	logic [2:0] frameDelaySec;
	logic [2:0] saPort = 3'h0;
	logic [6:0] bcastThreshold, normalGapBt, bpGapBt;
	logic [6:0] bcastCount = 7'h00;
	logic [7:0] phyResetReq, fwdDestMask;
	logic [7:0] fwdVlanMask = 8'h5F, srcMacLow = 8'hE4, linkDown = 8'h00;
	logic [1:0] trunkMember;
	logic [1:0] trunkAssign = 2'h0;
	logic fwdReq = 1'b0, trunkReq = 1'b0, rxReq = 1'b0, saKnown = 1'b0, bcastArrive = 1'b0;
	int failCount = 0, comparisons = 0, i, m, n;
	// expected depths, gaps and free block thresholds by code
	logic [9:0] ql16 [4] = '{10'h080, 10'h200, 10'h300, 10'h000};
	logic [9:0] ql8 [4] = '{10'h040, 10'h100, 10'h180, 10'h000};
	logic [6:0] gp [4] = '{7'h30, 7'h38, 7'h41, 7'h48};
	logic [9:0] wm [4] = '{10'h004, 10'h008, 10'h010, 10'h001};

	// short aging second keeps the scan checks brief
	scb_config_bank #(.SEC_CYCLES(10)) scb_config_bank_i (.*);

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc

	// write lands on the next edge, derived fields one edge later
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge core_clk) regReq <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk) regReq <= '0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		@(posedge core_clk) regReq <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge core_clk) regReq <= '0;
		#1 chk(regRdValid, 16'h0001);
		chk(regRdData, exp);
	endtask : rd

	task automatic trk(input logic [1:0] as, input logic [1:0] exp);
		@(posedge core_clk) begin
			trunkReq <= 1'b1;
			trunkAssign <= as;
		end
		@(posedge core_clk) trunkReq <= 1'b0;
		#1 chk(trunkValid, 16'h0001);
		chk(trunkMember, exp);
	endtask : trk

	task automatic fwd(input logic [7:0] exp);
		@(posedge core_clk) fwdReq <= 1'b1;
		@(posedge core_clk) fwdReq <= 1'b0;
		#1 chk(fwdDestValid, 16'h0001);
		chk(fwdDestMask, exp);
	endtask : fwd

	task automatic rx(input logic k, input logic [2:0] p, input logic exp);
		@(posedge core_clk) begin
			rxReq <= 1'b1;
			saKnown <= k;
			saPort <= p;
		end
		@(posedge core_clk) rxReq <= 1'b0;
		#1 chk(rxValid, 16'h0001);
		chk(rxDrop, exp);
	endtask : rx

	// storm flag lags the count, so let it settle before the arrival
	task automatic bc(input logic [6:0] c, input logic exp);
		@(posedge core_clk) bcastCount <= c;
		cyc(2);
		@(posedge core_clk) bcastArrive <= 1'b1;
		@(posedge core_clk) bcastArrive <= 1'b0;
		#1 chk(bcastDrop, exp);
	endtask : bc

	task automatic scans(input int lo, input int hi);
		n = 0;
		repeat (200) begin
			cyc(1);
			n += ageScan;
		end
		chk(16'(n >= lo && n <= hi), 16'h0001);
	endtask : scans

	task automatic finalReport();
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finalReport

	// watchdog well beyond the expected run of under a thousand cycles
	initial begin
		repeat (30000) @(posedge core_clk);
		failCount++;
		finalReport();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		cyc(2);
		chk(normalGapBt, 16'h0060);
		chk(queueLimit, 16'h0040);
		chk(frameTimeoutOn, 16'h0001);
		rd(scb_pkg::OFS_CHECKSUM, 16'h2900);
		rd(scb_pkg::OFS_TEST, 16'h0008);
		wr(scb_pkg::OFS_RSVD, 16'hFFFF);
		rd(scb_pkg::OFS_RSVD, 16'h0114);
		rd(7'h10, 16'h0000);
		wr(scb_pkg::OFS_IND3, 16'hA55A);
		rd(scb_pkg::OFS_IND3, 16'hA55A);
		wr(scb_pkg::OFS_SYS1, 16'hFFFF);
		rd(scb_pkg::OFS_SYS1, 16'hF3EC);
		chk({queueLimited, queueTestMode, agingEnable, portZeroMiiMode}, 16'h000F);
		chk({ingressMirrorEnable, egressMirrorEnable, frameTimeoutOn}, 16'h0006);
		for (m = 0; m < 2; m++)
			for (i = 0; i < 4; i++) begin
				wr(scb_pkg::OFS_SYS3, 16'(m << 5));
				wr(scb_pkg::OFS_SYS1, 16'(16'h8008 | (i << 6)));
				chk(queueLimit, m ? ql16[i] : ql8[i]);
			end
		// write then read in the very next cycle
		@(posedge core_clk) regReq <= '{1'b1, 1'b0, scb_pkg::OFS_SYS2, 16'h5A3C};
		@(posedge core_clk) regReq <= '{1'b0, 1'b1, scb_pkg::OFS_SYS2, 16'h0000};
		@(posedge core_clk) regReq <= '0;
		#1 chk(regRdData, 16'h5A3C);
		for (i = 0; i < 4; i++) begin
			wr(scb_pkg::OFS_SYS2, 16'(i * 16'h5555));
			chk(ageLimitSec, 16'(i * 85 + 1));
			chk({frameDelaySec, bcastThreshold}, 16'(144 * (i + 1)));
			chk({shortBackoffEnable, excessCollisionRetry}, 16'(i));
			trk(~i[1:0], i[1:0]);
			wr(scb_pkg::OFS_SYS3, 16'(16'h0200 | (i << 2) | ((i & 1) * 16'h0110)));
			chk(bpGapBt, gp[i]);
			chk({normalGapBt, bpCollisionMode}, (i & 1) ? 16'h0081 : 16'h00C0);
			wr(scb_pkg::OFS_TEST, 16'(i << 10));
			@(posedge core_clk) freeBlocks <= wm[i] - 10'h001;
			cyc(2);
			chk(bpAssert, 16'(i < 3));
			@(posedge core_clk) freeBlocks <= wm[i];
			cyc(2);
			chk(bpAssert, 16'h0000);
		end
		wr(scb_pkg::OFS_SYS1, 16'h0000);
		trk(2'h2, 2'h2);
		wr(scb_pkg::OFS_SYS3, 16'h000C);
		chk(bpGapBt, 16'h0060);
		wr(scb_pkg::OFS_MIRROR, 16'hCCBA);
		chk({monitoredPortId, ingressSnoopPortId, egressSnoopPortId}, 16'h4CBA);
		wr(scb_pkg::OFS_PHYV, 16'hE000);
		chk({phyAddrBase, mgmtClockSlow, phyPortOrderReverse}, 16'h0043);
		@(posedge core_clk) linkDown <= 8'h85;
		@(posedge core_clk) linkDown <= 8'h00;
		#1 chk(phyResetReq, 16'h0085);
		wr(scb_pkg::OFS_SYS3, 16'h4000);
		@(posedge core_clk) linkDown <= 8'h81;
		@(posedge core_clk) linkDown <= 8'h00;
		#1 chk(phyResetReq, 16'h0000);
		wr(scb_pkg::OFS_PORT0, 16'h0C0C);
		fwd(8'h5E);
		wr(scb_pkg::OFS_SYS1, 16'h6000);
		fwd(8'h08);
		wr(scb_pkg::OFS_PORT0, 16'h0C4C);
		rx(1'b1, 3'h0, 1'b0);
		chk(portZeroDisabled, 16'h0000);
		rx(1'b1, 3'h5, 1'b1);
		chk(portZeroDisabled, 16'h0001);
		rx(1'b0, 3'h0, 1'b1);
		chk(portZeroDisabled, 16'h0001);
		wr(scb_pkg::OFS_SYS1, 16'h0000);
		wr(scb_pkg::OFS_PORT0, 16'h0C4C);
		rx(1'b0, 3'h0, 1'b1);
		chk(portZeroDisabled, 16'h0000);
		wr(scb_pkg::OFS_PORT0, 16'h0C8C);
		rx(1'b0, 3'h0, 1'b0);
		wr(scb_pkg::OFS_SYS2, 16'h0000);
		bc(7'd17, 1'b1);
		bc(7'd16, 1'b1);
		bc(7'd15, 1'b0);
		bc(7'd16, 1'b0);
		wr(scb_pkg::OFS_PORT0, 16'h0C0C);
		bc(7'd40, 1'b0);
		wr(scb_pkg::OFS_SYS1, 16'h1000);
		scans(19, 21);
		wr(scb_pkg::OFS_SYS3, 16'h0400);
		scans(9, 11);
		wr(scb_pkg::OFS_SYS1, 16'h0000);
		scans(0, 0);
		finalReport();
	end
endmodule : tb
